// ===== design/oims_consts.svh
// Function
// - Fault code: 0 none, 1 short, 2 current range, 3 supply, 4 link, 5 clock, 74 heat.
// - Identity reads zero while the slot is empty.
// - Identity shows the fitted module's code, 0 to 599, read only.
// - A newly fitted category loads that category's default settings.
// - Save only after 1000 is written and stop/reset; option code stored too.
// - Power-up compares fitted module with stored code; mismatch or missing trips.
// - Software version reads major.minor 00.00 to 99.99, plus a sub-version field.
// - Loop loss flag sets in analog modes 2 to 5 when current below 3mA.
// - Loop loss flag may be chosen as a digital output source.
// - Each of three inputs has a read-only state bit, 1 meaning active.
// - Inputs use positive logic only, with no polarity setting.
// - Each input has an invert bit complementing the value sent to its destination.
// - Relay state reads 0 de-energized and 1 energized.
// - Relay invert bit, default 0, inverts the relay drive sense.
// - Daylight bit 0 keeps normal clock time, 1 presents time one hour ahead.
// - A detected module fault is written as its reason into the fault status only while it reads zero (or on drive reset); the highest priority fault wins.
// - Drive reset clears the fault status back to zero.
`ifndef OIMS_CONSTS_SVH
`define OIMS_CONSTS_SVH

`define OIMS_ADDR_W 8
`define OIMS_OFS_IDENTITY 8'h00
`define OIMS_OFS_SW_VERSION 8'h04
`define OIMS_OFS_SUB_VERSION 8'h08
`define OIMS_OFS_FAULT 8'h0c
`define OIMS_OFS_LOOP_LOSS 8'h10
`define OIMS_OFS_IN_ONE_STATE 8'h14
`define OIMS_OFS_IN_TWO_STATE 8'h18
`define OIMS_OFS_IN_THREE_STATE 8'h1c
`define OIMS_OFS_RELAY_STATE 8'h20
`define OIMS_OFS_IN_ONE_INV 8'h24
`define OIMS_OFS_IN_TWO_INV 8'h28
`define OIMS_OFS_IN_THREE_INV 8'h2c
`define OIMS_OFS_RELAY_INV 8'h30
`define OIMS_OFS_DAYLIGHT 8'h34
`define OIMS_OFS_SAVE_CMD 8'h38
`define OIMS_OFS_ANALOG_MODE 8'h3c
`define OIMS_OFS_DOUT_SEL 8'h40
`define OIMS_OFS_IRQ_STATUS 8'h44
`define OIMS_OFS_IRQ_MASK 8'h48
`define OIMS_OFS_TRIPS 8'h4c

`define OIMS_SAVE_KEY 16'h03e8
`define OIMS_LOOP_MIN_UA 16'h0bb8
`define OIMS_LOOP_MODE_LO 3'h2
`define OIMS_LOOP_MODE_HI 3'h5
`define OIMS_HOUR_MAX 5'h17
`define OIMS_DAY_MIN 3'h1
`define OIMS_DAY_MAX 3'h7

`define OIMS_IRQ_FAULT 0
`define OIMS_IRQ_LOOP 1
`define OIMS_IRQ_CHANGED 2
`define OIMS_IRQ_ABSENT 3
`define OIMS_IRQ_CATEGORY 4
`define OIMS_IRQ_INPUT 5

`define OIMS_RST_INVERT 1'h0
`define OIMS_RST_RELAY_INV 1'h0
`define OIMS_RST_DAYLIGHT 1'h0

`endif

// ===== design/oims_pkg.sv
package oims_pkg;

	typedef enum logic [6:0] {
		OIMS_FLT_NONE = 7'h00,
		OIMS_FLT_SHORT = 7'h01,
		OIMS_FLT_CURRENT = 7'h02,
		OIMS_FLT_SUPPLY = 7'h03,
		OIMS_FLT_LINK = 7'h04,
		OIMS_FLT_CLOCK = 7'h05,
		OIMS_FLT_OVERTEMP = 7'h4a
	} oims_fault_t;

	typedef enum logic [1:0] {
		OIMS_PH_CHECK = 2'b00,
		OIMS_PH_RUN = 2'b01
	} oims_phase_t;

	typedef struct packed {
		oims_phase_t phase_r;
		logic [9:0] module_id_r;
		logic [13:0] sw_version_r;
		logic [6:0] sub_version_r;
		oims_fault_t fault_r;
		logic loop_loss_r;
		logic [2:0] in_state_r;
		logic relay_state_r;
		logic [2:0] in_invert_r;
		logic relay_invert_r;
		logic daylight_r;
		logic [15:0] save_cmd_r;
		logic [2:0] analog_mode_r;
		logic dout_select_r;
		logic [5:0] irq_status_r;
		logic [5:0] irq_mask_r;
		logic changed_trip_r;
		logic absent_trip_r;
		logic [31:0] prdata_r;
		logic pready_r;
		logic pslverr_r;
		logic irq_r;
		logic [2:0] in_route_r;
		logic relay_drive_r;
		logic dout_r;
		logic save_strobe_r;
		logic [9:0] save_code_r;
		logic load_defaults_r;
		logic [4:0] rtc_hours_r;
		logic [2:0] rtc_day_r;
		logic fault_trip_r;
	} oims_state_t;

endpackage

// ===== design/oims_sync.sv
`timescale 1ns/100ps
module oims_sync #(
	parameter int WIDTH = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta_r;
		logic [WIDTH-1:0] sync_r;
	} oims_sync_t;

	oims_sync_t st_r;
	oims_sync_t st_nxt;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("oims_sync: WIDTH must be at least 1");
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		st_nxt.meta_r = d;
		st_nxt.sync_r = st_r.meta_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.sync_r;
endmodule

// ===== design/oims_top.sv
`timescale 1ns/100ps
`include "oims_consts.svh"
module oims_top
	import oims_pkg::*;
#(
	parameter int N_INPUTS = 3,
	parameter int ID_MAX = 599
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic module_present,
	input wire logic [9:0] module_id_in,
	input wire logic [13:0] module_version_in,
	input wire logic [6:0] module_sub_version_in,
	input wire logic [9:0] stored_option_code,
	input wire logic stop_reset_press,
	input wire logic drive_reset,
	input wire logic fault_output_short,
	input wire logic fault_current_range,
	input wire logic fault_supply_overcurrent,
	input wire logic fault_serial_link,
	input wire logic fault_clock,
	input wire logic fault_overtemp,
	input wire logic [15:0] loop_current_ua,
	input wire logic input_terminal_one,
	input wire logic input_terminal_two,
	input wire logic input_terminal_three,
	input wire logic relay_source,
	input wire logic dout_source,
	input wire logic [4:0] rtc_hours_in,
	input wire logic [2:0] rtc_day_in,
	output logic input_route_one,
	output logic input_route_two,
	output logic input_route_three,
	output logic relay_terminal_drive,
	output logic digital_output,
	output logic save_strobe,
	output logic [9:0] save_option_code,
	output logic load_defaults,
	output logic [4:0] rtc_hours_out,
	output logic [2:0] rtc_day_out,
	output logic slot_module_fault_trip,
	output logic slot_module_changed_trip,
	output logic slot_module_absent_trip
);

	generate
		if (N_INPUTS != 3) begin : g_chk_inputs
			$error("oims_top: exactly three digital inputs are supported");
		end
		if (ID_MAX < 1 || ID_MAX > 1023) begin : g_chk_id
			$error("oims_top: ID_MAX must fit the 10-bit identity field");
		end
	endgenerate

	oims_state_t st_r;
	oims_state_t st_nxt;
	logic [2:0] in_sync;
	logic [`OIMS_ADDR_W-1:0] addr;
	logic setup_phase;
	logic access_done;
	logic [9:0] fitted_id;

	// Positive logic only: terminals are synchronised with no polarity option
	oims_sync #(
		.WIDTH(3)
	) oims_sync_i (
		.pclk(pclk),
		.presetn(presetn),
		.d({input_terminal_three, input_terminal_two, input_terminal_one}),
		.q(in_sync)
	);

	// Highest priority fault reason
	function automatic oims_fault_t fault_pick(
		input logic f_short,
		input logic f_current,
		input logic f_supply,
		input logic f_link,
		input logic f_clock,
		input logic f_heat
	);
		oims_fault_t code;
		code = OIMS_FLT_NONE;
		if (f_heat) begin
			code = OIMS_FLT_OVERTEMP;
		end else if (f_short) begin
			code = OIMS_FLT_SHORT;
		end else if (f_current) begin
			code = OIMS_FLT_CURRENT;
		end else if (f_supply) begin
			code = OIMS_FLT_SUPPLY;
		end else if (f_link) begin
			code = OIMS_FLT_LINK;
		end else if (f_clock) begin
			code = OIMS_FLT_CLOCK;
		end
		return code;
	endfunction

	// Identity of what sits in the slot; zero when empty or out of range
	function automatic logic [9:0] id_of(
		input logic present,
		input logic [9:0] raw
	);
		logic [9:0] id;
		id = 10'h000;
		if (present && (raw <= 10'(ID_MAX))) begin
			id = raw;
		end
		return id;
	endfunction

	// Register read mux
	function automatic logic [31:0] read_mux(
		input logic [`OIMS_ADDR_W-1:0] a,
		input oims_state_t s
	);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			`OIMS_OFS_IDENTITY: d[9:0] = s.module_id_r;
			`OIMS_OFS_SW_VERSION: d[13:0] = s.sw_version_r;
			`OIMS_OFS_SUB_VERSION: d[6:0] = s.sub_version_r;
			`OIMS_OFS_FAULT: d[6:0] = s.fault_r;
			`OIMS_OFS_LOOP_LOSS: d[0] = s.loop_loss_r;
			`OIMS_OFS_IN_ONE_STATE: d[0] = s.in_state_r[0];
			`OIMS_OFS_IN_TWO_STATE: d[0] = s.in_state_r[1];
			`OIMS_OFS_IN_THREE_STATE: d[0] = s.in_state_r[2];
			`OIMS_OFS_RELAY_STATE: d[0] = s.relay_state_r;
			`OIMS_OFS_IN_ONE_INV: d[0] = s.in_invert_r[0];
			`OIMS_OFS_IN_TWO_INV: d[0] = s.in_invert_r[1];
			`OIMS_OFS_IN_THREE_INV: d[0] = s.in_invert_r[2];
			`OIMS_OFS_RELAY_INV: d[0] = s.relay_invert_r;
			`OIMS_OFS_DAYLIGHT: d[0] = s.daylight_r;
			`OIMS_OFS_SAVE_CMD: d[15:0] = s.save_cmd_r;
			`OIMS_OFS_ANALOG_MODE: d[2:0] = s.analog_mode_r;
			`OIMS_OFS_DOUT_SEL: d[0] = s.dout_select_r;
			`OIMS_OFS_IRQ_STATUS: d[5:0] = s.irq_status_r;
			`OIMS_OFS_IRQ_MASK: d[5:0] = s.irq_mask_r;
			`OIMS_OFS_TRIPS: d[1:0] = {s.absent_trip_r, s.changed_trip_r};
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	function automatic logic mapped(
		input logic [31:0] a
	);
		logic ok;
		ok = (a[31:`OIMS_ADDR_W] == '0) && (a[1:0] == 2'b00)
			&& (a[`OIMS_ADDR_W-1:0] <= `OIMS_OFS_TRIPS);
		return ok;
	endfunction

	assign addr = paddr[`OIMS_ADDR_W-1:0];
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && st_r.pready_r;
	assign fitted_id = id_of(module_present, module_id_in);

	always_comb begin
		logic [5:0] ev;
		logic [5:0] clr;
		oims_fault_t new_fault;
		logic loop_low;
		logic new_cat;
		logic [4:0] hr;
		logic [2:0] dy;
		ev = 6'h00;
		clr = 6'h00;
		new_fault = OIMS_FLT_NONE;
		loop_low = 1'b0;
		new_cat = 1'b0;
		hr = rtc_hours_in;
		dy = rtc_day_in;
		st_nxt = st_r;
		st_nxt.save_strobe_r = 1'b0;
		st_nxt.load_defaults_r = 1'b0;

		// Drive reset clears trips; a power-up mismatch in the same cycle still trips
		if (drive_reset) begin
			st_nxt.changed_trip_r = 1'b0;
			st_nxt.absent_trip_r = 1'b0;
		end

		// Identity, version and power-up option check
		unique case (st_r.phase_r)
			OIMS_PH_CHECK: begin
				st_nxt.phase_r = OIMS_PH_RUN;
				st_nxt.module_id_r = fitted_id;
				if (stored_option_code != 10'h000 && fitted_id == 10'h000) begin
					st_nxt.absent_trip_r = 1'b1;
					ev[`OIMS_IRQ_ABSENT] = 1'b1;
				end else if (fitted_id != stored_option_code) begin
					st_nxt.changed_trip_r = 1'b1;
					ev[`OIMS_IRQ_CHANGED] = 1'b1;
					new_cat = 1'b1;
				end
			end
			OIMS_PH_RUN: begin
				st_nxt.module_id_r = fitted_id;
				if (fitted_id != 10'h000 && fitted_id != st_r.module_id_r) begin
					new_cat = 1'b1;
				end
			end
			default: st_nxt.phase_r = OIMS_PH_CHECK;
		endcase
		if (new_cat) begin
			st_nxt.load_defaults_r = 1'b1;
			st_nxt.in_invert_r = {3{`OIMS_RST_INVERT}};
			st_nxt.relay_invert_r = `OIMS_RST_RELAY_INV;
			st_nxt.daylight_r = `OIMS_RST_DAYLIGHT;
			st_nxt.analog_mode_r = 3'h0;
			st_nxt.dout_select_r = 1'b0;
			ev[`OIMS_IRQ_CATEGORY] = 1'b1;
		end
		if (module_present) begin
			st_nxt.sw_version_r = module_version_in;
			st_nxt.sub_version_r = module_sub_version_in;
		end else begin
			st_nxt.sw_version_r = 14'h0000;
			st_nxt.sub_version_r = 7'h00;
		end

		// Fault status: first reason held until drive reset
		new_fault = fault_pick(fault_output_short, fault_current_range,
			fault_supply_overcurrent, fault_serial_link, fault_clock, fault_overtemp);
		if (drive_reset) begin
			st_nxt.fault_r = OIMS_FLT_NONE;
		end
		if (new_fault != OIMS_FLT_NONE && (st_r.fault_r == OIMS_FLT_NONE || drive_reset)) begin
			st_nxt.fault_r = new_fault;
			ev[`OIMS_IRQ_FAULT] = 1'b1;
		end
		st_nxt.fault_trip_r = (st_nxt.fault_r != OIMS_FLT_NONE);

		// Current loop loss
		if (st_r.analog_mode_r >= `OIMS_LOOP_MODE_LO && st_r.analog_mode_r <= `OIMS_LOOP_MODE_HI) begin
			loop_low = (loop_current_ua < `OIMS_LOOP_MIN_UA);
		end
		st_nxt.loop_loss_r = loop_low;
		if (loop_low && !st_r.loop_loss_r) begin
			ev[`OIMS_IRQ_LOOP] = 1'b1;
		end
		st_nxt.dout_r = st_r.dout_select_r ? st_r.loop_loss_r : dout_source;

		// Digital inputs and routing
		st_nxt.in_state_r = in_sync;
		st_nxt.in_route_r = in_sync ^ st_r.in_invert_r;
		if (in_sync != st_r.in_state_r) begin
			ev[`OIMS_IRQ_INPUT] = 1'b1;
		end

		// Relay
		st_nxt.relay_drive_r = relay_source ^ st_r.relay_invert_r;
		st_nxt.relay_state_r = st_r.relay_drive_r;

		// Clock presentation
		if (st_r.daylight_r) begin
			if (rtc_hours_in >= `OIMS_HOUR_MAX) begin
				hr = 5'h00;
				dy = (rtc_day_in >= `OIMS_DAY_MAX) ? `OIMS_DAY_MIN : 3'(rtc_day_in + 3'h1);
			end else begin
				hr = 5'(rtc_hours_in + 5'h01);
			end
		end
		st_nxt.rtc_hours_r = hr;
		st_nxt.rtc_day_r = dy;

		// Parameter save on stop/reset after key
		if (stop_reset_press && st_r.save_cmd_r == `OIMS_SAVE_KEY) begin
			st_nxt.save_strobe_r = 1'b1;
			st_nxt.save_code_r = st_r.module_id_r;
			st_nxt.save_cmd_r = 16'h0000;
		end

		// APB slave: no wait states, answer in first access cycle
		st_nxt.pready_r = setup_phase;
		if (setup_phase) begin
			st_nxt.prdata_r = read_mux(addr, st_r);
			st_nxt.pslverr_r = !mapped(paddr);
		end
		if (access_done) begin
			st_nxt.pslverr_r = 1'b0;
			st_nxt.prdata_r = 32'h0000_0000;
			if (!pwrite && addr == `OIMS_OFS_IRQ_STATUS) begin
				clr = st_r.irq_status_r;
			end
			if (pwrite && mapped(paddr)) begin
				unique case (addr)
					`OIMS_OFS_IN_ONE_INV: st_nxt.in_invert_r[0] = pwdata[0];
					`OIMS_OFS_IN_TWO_INV: st_nxt.in_invert_r[1] = pwdata[0];
					`OIMS_OFS_IN_THREE_INV: st_nxt.in_invert_r[2] = pwdata[0];
					`OIMS_OFS_RELAY_INV: st_nxt.relay_invert_r = pwdata[0];
					`OIMS_OFS_DAYLIGHT: st_nxt.daylight_r = pwdata[0];
					`OIMS_OFS_SAVE_CMD: st_nxt.save_cmd_r = pwdata[15:0];
					`OIMS_OFS_ANALOG_MODE: st_nxt.analog_mode_r = pwdata[2:0];
					`OIMS_OFS_DOUT_SEL: st_nxt.dout_select_r = pwdata[0];
					`OIMS_OFS_IRQ_MASK: st_nxt.irq_mask_r = pwdata[5:0];
					default: st_nxt.irq_mask_r = st_r.irq_mask_r;
				endcase
			end
		end

		// Sticky events, set wins over read-clear
		st_nxt.irq_status_r = (st_r.irq_status_r & ~clr) | ev;
		st_nxt.irq_r = |(st_nxt.irq_status_r & st_nxt.irq_mask_r);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata_r;
	assign pready = st_r.pready_r;
	assign pslverr = st_r.pslverr_r;
	assign irq = st_r.irq_r;
	assign input_route_one = st_r.in_route_r[0];
	assign input_route_two = st_r.in_route_r[1];
	assign input_route_three = st_r.in_route_r[2];
	assign relay_terminal_drive = st_r.relay_drive_r;
	assign digital_output = st_r.dout_r;
	assign save_strobe = st_r.save_strobe_r;
	assign save_option_code = st_r.save_code_r;
	assign load_defaults = st_r.load_defaults_r;
	assign rtc_hours_out = st_r.rtc_hours_r;
	assign rtc_day_out = st_r.rtc_day_r;
	assign slot_module_fault_trip = st_r.fault_trip_r;
	assign slot_module_changed_trip = st_r.changed_trip_r;
	assign slot_module_absent_trip = st_r.absent_trip_r;
endmodule

// ===== tb/oims_host.sv
`timescale 1ns/100ps
module oims_host (
	input wire logic pclk,
	input wire logic save_strobe,
	input wire logic [9:0] save_option_code,
	input wire logic input_route_one,
	output logic [9:0] stored_option_code,
	output logic external_trip
);
	// Stored code survives device reset
	initial stored_option_code = 10'h000;
	always @(posedge pclk) begin
		if (save_strobe) begin
			stored_option_code <= save_option_code;
		end
	end
	assign external_trip = input_route_one;
endmodule

// ===== tb/oims_properties.sv
`timescale 1ns/100ps
module oims_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic drive_reset,
	input wire logic fault_overtemp,
	input wire logic save_strobe,
	input wire logic load_defaults,
	input wire logic slot_module_fault_trip,
	input wire logic slot_module_changed_trip,
	input wire logic slot_module_absent_trip
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic setup;
	logic bad;
	assign setup = psel && !penable;
	assign bad = paddr > 32'h4c || paddr[1:0] != 2'h0;
	setup_answer_a: assert property (setup |=> pready)
		else $error("no answer to setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	bad_addr_a: assert property (setup && bad |=> pslverr)
		else $error("bad address not refused");
	good_addr_a: assert property (setup && !bad |=> !pslverr)
		else $error("good address refused");
	err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("refused read data not zero");
	heat_trip_a: assert property (fault_overtemp |=> slot_module_fault_trip)
		else $error("heat fault gave no trip");
	trip_clear_a: assert property (drive_reset && $past(presetn) |=> !slot_module_changed_trip)
		else $error("changed trip not cleared");
	save_pulse_a: assert property ($rose(save_strobe) |=> !save_strobe)
		else $error("save strobe too long");
	defaults_pulse_a: assert property (load_defaults |=> !load_defaults)
		else $error("defaults pulse too long");
	cover property (setup && bad);
	cover property (save_strobe);
	cover property (irq);
endmodule

bind oims_top oims_properties oims_properties_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq(irq), .drive_reset(drive_reset), .fault_overtemp(fault_overtemp),
	.save_strobe(save_strobe), .load_defaults(load_defaults),
	.slot_module_fault_trip(slot_module_fault_trip),
	.slot_module_changed_trip(slot_module_changed_trip),
	.slot_module_absent_trip(slot_module_absent_trip));

// ===== tb/option_io_module_status_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module option_io_module_status_tb;
	typedef struct {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] q; logic e;} oims_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, ext;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic module_present, stop_reset_press, drive_reset, relay_source, dout_source;
	logic [9:0] module_id_in, stored_option_code, save_option_code;
	logic [5:0] flt;
	logic [15:0] loop_current_ua;
	logic [2:0] term, route, rtc_day_in, rtc_day_out;
	logic [4:0] rtc_hours_in, rtc_hours_out;
	logic relay_terminal_drive, digital_output, save_strobe, load_defaults;
	logic slot_module_fault_trip, slot_module_changed_trip, slot_module_absent_trip;
	int fails, check_count, ld;
	logic [31:0] codes [6] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h4a};
	oims_row_t rows [14] = '{
		'{1'h0, 8'h00, 16'h0, 16'h123, 1'h0}, '{1'h1, 8'h00, 16'h5, 16'h0, 1'h0},
		'{1'h0, 8'h00, 16'h0, 16'h123, 1'h0}, '{1'h0, 8'h04, 16'h0, 16'h4d2, 1'h0},
		'{1'h0, 8'h08, 16'h0, 16'h2a, 1'h0}, '{1'h0, 8'h0c, 16'h0, 16'h0, 1'h0},
		'{1'h0, 8'h30, 16'h0, 16'h0, 1'h0}, '{1'h0, 8'h34, 16'h0, 16'h0, 1'h0},
		'{1'h0, 8'h50, 16'h0, 16'h0, 1'h1}, '{1'h1, 8'h02, 16'h1, 16'h0, 1'h1},
		'{1'h1, 8'h30, 16'h1, 16'h0, 1'h0}, '{1'h1, 8'h34, 16'h1, 16'h0, 1'h0},
		'{1'h1, 8'h24, 16'h1, 16'h0, 1'h0}, '{1'h1, 8'h48, 16'h1, 16'h0, 1'h0}};
	oims_top oims_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq, .module_present, .module_id_in, .module_version_in(14'h04d2),
		.module_sub_version_in(7'h2a), .stored_option_code, .stop_reset_press, .drive_reset,
		.fault_output_short(flt[0]), .fault_current_range(flt[1]),
		.fault_supply_overcurrent(flt[2]), .fault_serial_link(flt[3]), .fault_clock(flt[4]),
		.fault_overtemp(flt[5]), .loop_current_ua, .input_terminal_one(term[0]),
		.input_terminal_two(term[1]), .input_terminal_three(term[2]), .relay_source,
		.dout_source, .rtc_hours_in, .rtc_day_in, .input_route_one(route[0]),
		.input_route_two(route[1]), .input_route_three(route[2]), .relay_terminal_drive,
		.digital_output, .save_strobe, .save_option_code, .load_defaults, .rtc_hours_out,
		.rtc_day_out, .slot_module_fault_trip, .slot_module_changed_trip,
		.slot_module_absent_trip);
	oims_host oims_host_i (.pclk, .save_strobe, .save_option_code,
		.input_route_one(route[0]), .stored_option_code, .external_trip(ext));
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] q);
		apb(1'b0, a, 32'h0);
		`CHK(rd, q)
	endtask
	task automatic rst;
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask
	task automatic end_sim;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (load_defaults === 1'b1) begin
			ld++;
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		$display("Error t=%0t got %h exp %h", $time, 1'b0, 1'b1);
		end_sim;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{stop_reset_press, drive_reset, relay_source, flt, term} = '0;
		{module_present, module_id_in, dout_source} = {1'b1, 10'h123, 1'b1};
		{loop_current_ua, rtc_hours_in, rtc_day_in} = {16'h0bb8, 5'h17, 3'h7};
		rst;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, {16'h0, rows[i].d});
			if (!rows[i].w) `CHK(rd, {16'h0, rows[i].q})
			`CHK(err, rows[i].e)
		end
		term <= 3'h3;
		relay_source <= 1'b1;
		repeat (4) @(posedge pclk);
		`CHK(route, 3'h2)
		`CHK(ext, 1'b0)
		`CHK({rtc_hours_out, rtc_day_out}, {5'h00, 3'h1})
		`CHK(relay_terminal_drive, 1'b0)
		rchk(8'h20, 32'h0);
		rchk(8'h14, 32'h1);
		rchk(8'h1c, 32'h0);
		apb(1'b1, 8'h30, 32'h0);
		repeat (2) @(posedge pclk);
		`CHK(relay_terminal_drive, 1'b1)
		rchk(8'h20, 32'h1);
		loop_current_ua <= 16'h0bb7;
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, 8'h3c, 32'(m));
			repeat (2) @(posedge pclk);
			rchk(8'h10, 32'(m >= 2 && m <= 5));
		end
		`CHK(digital_output, 1'b1)
		apb(1'b1, 8'h3c, 32'h2);
		apb(1'b1, 8'h40, 32'h1);
		loop_current_ua <= 16'h0bb8;
		repeat (3) @(posedge pclk);
		`CHK(digital_output, 1'b0)
		loop_current_ua <= 16'h0bb7;
		repeat (3) @(posedge pclk);
		`CHK(digital_output, 1'b1)
		for (int i = 0; i < 6; i++) begin
			flt <= 6'h1 << i;
			@(posedge pclk);
			flt <= 6'h0;
			repeat (2) @(posedge pclk);
			rchk(8'h0c, codes[i]);
			`CHK({slot_module_fault_trip, irq}, 2'h3)
			drive_reset <= 1'b1;
			@(posedge pclk);
			drive_reset <= 1'b0;
			apb(1'b0, 8'h44, 32'h0);
			`CHK(rd[0], 1'b1)
			rchk(8'h0c, 32'h0);
			`CHK(irq, 1'b0)
		end
		apb(1'b1, 8'h38, 32'h3e7);
		for (int k = 0; k < 2; k++) begin
			stop_reset_press <= 1'b1;
			@(posedge pclk);
			stop_reset_press <= 1'b0;
			repeat (2) @(posedge pclk);
			`CHK(stored_option_code, k ? 10'h123 : 10'h000)
			apb(1'b1, 8'h38, 32'h3e8);
		end
		module_present <= 1'b0;
		rst;
		`CHK(slot_module_absent_trip, 1'b1)
		rchk(8'h4c, 32'h2);
		rchk(8'h00, 32'h0);
		{module_present, module_id_in} <= {1'b1, 10'h124};
		ld = 0;
		rst;
		`CHK({slot_module_changed_trip, ld}, {1'b1, 32'h1})
		rchk(8'h34, 32'h0);
		drive_reset <= 1'b1;
		@(posedge pclk);
		drive_reset <= 1'b0;
		@(posedge pclk);
		`CHK(slot_module_changed_trip, 1'b0)
		end_sim;
	end
endmodule
